// file: hdl/uip_top.v
// uart interrupt prioritizer: latches source events, ranks them and reports
// the one most urgent when captured, through a read-to-clear identification register.
// assumes source events are one-cycle pulses from logic on CLK; xoff/xon pulses likewise
`timescale 1ns/1ps
`include "uip_map.vh"

module uip_top
(
  CLK,
  RST,
  AVS_ADDRESS,
  AVS_READ,
  AVS_WRITE,
  AVS_WRITEDATA,
  AVS_BYTEENABLE,
  AVS_READDATA,
  AVS_WAITREQUEST,
  AVS_RESPONSE,
  LINE_STATUS_SOURCE,
  RX_DATA_READY,
  RX_TIMEOUT,
  RX_COUNT,
  TX_HOLDING_EMPTY,
  MODEM_STATUS_SOURCE,
  XOFF_DETECTED,
  XON_DETECTED,
  SPECIAL_CHAR,
  FLOW_CHANGE,
  IRQ
);

  input wire CLK;
  input wire RST;
  input wire [3:0] AVS_ADDRESS;
  input wire AVS_READ;
  input wire AVS_WRITE;
  input wire [31:0] AVS_WRITEDATA;
  input wire [3:0] AVS_BYTEENABLE;
  output reg [31:0] AVS_READDATA;
  output reg AVS_WAITREQUEST;
  output reg [1:0] AVS_RESPONSE;
  input wire LINE_STATUS_SOURCE;
  input wire RX_DATA_READY;
  input wire RX_TIMEOUT;
  input wire [4:0] RX_COUNT;
  input wire TX_HOLDING_EMPTY;
  input wire MODEM_STATUS_SOURCE;
  input wire XOFF_DETECTED;
  input wire XON_DETECTED;
  input wire SPECIAL_CHAR;
  input wire FLOW_CHANGE;
  output reg IRQ;

  localparam ST_IDLE = 2'h0;
  localparam ST_ANS = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_q;
  reg [7:0] fifo_control_q;
  reg [7:0] enhanced_feature_control_q;
  reg [7:0] enable_q;
  reg [6:0] pend_q;
  reg [6:0] pend_d;
  reg xoff_hold_q;
  reg [2:0] cur_sel_q;
  reg cur_valid_q;
  reg [5:0] cur_code_q;
  reg rx_trig_prev_q;

  wire rank_any;
  wire [2:0] rank_sel;
  wire [5:0] rank_code;
  wire trig_hit;
  wire fifo_mode;
  wire enh_mode;
  wire rx_event;
  wire [6:0] events;
  wire [6:0] gated;
  wire ident_read;
  wire [7:0] ident_value;

  assign fifo_mode = fifo_control_q[`UIP_FCR_EN];
  assign enh_mode = enhanced_feature_control_q[`UIP_EFR_ENH];

  uip_trig u_trig
  (
    .trig_sel(fifo_control_q[`UIP_FCR_TRIG_HI:`UIP_FCR_TRIG_LO]),
    .rx_count(RX_COUNT),
    .hit(trig_hit)
  );

  // fifo mode raises data interrupt on reaching the trigger, plain mode on each byte
  assign rx_event = fifo_mode ? (trig_hit & ~rx_trig_prev_q) : RX_DATA_READY;

  assign events = {FLOW_CHANGE & enh_mode, (XOFF_DETECTED | SPECIAL_CHAR) & enh_mode, MODEM_STATUS_SOURCE,
                   TX_HOLDING_EMPTY, RX_TIMEOUT & fifo_mode, rx_event, LINE_STATUS_SOURCE};

  // disabled sources stay latched but hidden, so enabling later exposes them
  assign gated = pend_q & enable_q[6:0];

  uip_rank u_rank
  (
    .pend(gated),
    .any(rank_any),
    .sel(rank_sel),
    .code(rank_code)
  );

  assign ident_read = (state_q == ST_ANS) && AVS_READ && (AVS_ADDRESS == `UIP_ADDR_IDENT);

  // the reported source is frozen while unserviced so a higher arrival cannot displace it
  assign ident_value = {fifo_mode, fifo_mode,
                        (cur_valid_q ? cur_code_q[5:4] : 2'h0) | {1'b0, xoff_hold_q & enh_mode},
                        cur_valid_q ? cur_code_q[3:0] : 4'h1};

  always @*
  begin
    pend_d = pend_q;
    if (ident_read && cur_valid_q)
      pend_d[cur_sel_q] = 1'b0;
    pend_d = pend_d | events; // set wins over the read clear
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      fifo_control_q <= `UIP_RST_FCR;
      enhanced_feature_control_q <= `UIP_RST_EFR;
      enable_q <= `UIP_RST_IER;
      pend_q <= 7'h00;
      xoff_hold_q <= 1'b0;
      cur_sel_q <= 3'h0;
      cur_valid_q <= 1'b0;
      cur_code_q <= 6'h00;
      rx_trig_prev_q <= 1'b0;
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
      AVS_RESPONSE <= 2'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      rx_trig_prev_q <= trig_hit;
      pend_q <= pend_d;
      if (XOFF_DETECTED)
        xoff_hold_q <= 1'b1;
      else if (XON_DETECTED)
        xoff_hold_q <= 1'b0;
      // capture a new report only when nothing is awaiting service
      if (ident_read && cur_valid_q)
        cur_valid_q <= 1'b0;
      else if (!cur_valid_q && rank_any)
      begin
        cur_valid_q <= 1'b1;
        cur_sel_q <= rank_sel;
        cur_code_q <= rank_code;
      end
      IRQ <= |(pend_d & enable_q[6:0]);
      case (state_q)
        ST_IDLE:
        begin
          AVS_WAITREQUEST <= 1'b1;
          if (AVS_READ || AVS_WRITE)
            state_q <= ST_ANS;
        end
        ST_ANS:
        begin
          AVS_WAITREQUEST <= 1'b0;
          AVS_RESPONSE <= 2'h0;
          AVS_READDATA <= 32'h00000000;
          state_q <= ST_DONE;
          if (AVS_ADDRESS == `UIP_ADDR_IDENT)
          begin
            if (AVS_READ)
              AVS_READDATA <= {24'h000000, ident_value};
          end
          else if (AVS_ADDRESS == `UIP_ADDR_FIFO_CTRL)
          begin
            if (AVS_READ)
              AVS_READDATA <= {24'h000000, fifo_control_q};
            else if (AVS_BYTEENABLE[0])
              fifo_control_q <= AVS_WRITEDATA[7:0];
          end
          else if (AVS_ADDRESS == `UIP_ADDR_ENH_CTRL)
          begin
            if (AVS_READ)
              AVS_READDATA <= {24'h000000, enhanced_feature_control_q};
            else if (AVS_BYTEENABLE[0])
              enhanced_feature_control_q <= AVS_WRITEDATA[7:0];
          end
          else if (AVS_ADDRESS == `UIP_ADDR_ENABLE)
          begin
            if (AVS_READ)
              AVS_READDATA <= {24'h000000, enable_q};
            else if (AVS_BYTEENABLE[0])
              enable_q <= AVS_WRITEDATA[7:0];
          end
          else
            AVS_RESPONSE <= 2'h2;
        end
        default:
        begin
          AVS_WAITREQUEST <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: hdl/uip_map.vh
// register map, field positions, reset values and codes of the uart interrupt prioritizer
// assumes an avalon-mm slave with byte addressing of 32-bit registers
//
// Overview of operation
// - pending sources are ranked in six levels, level 1 most urgent
// - reading the identification register returns the code of the source ranked highest when the report was captured
// - while one interrupt awaits service, no other source is reported instead
// - a read clears only the reported interrupt; lower ones remain for later reads
// - line status is level 1, code 000110
// - received data available is level 2, code 000100
// - receive time-out is level 2, code 001100, bit 3 marks time-out
// - transmit holding empty is level 3 code 000010; modem status level 4 code 000000
// - received xoff or special character is level 5, code 010000
// - cts or rts change is level 6, code 100000
// - bits 7 and 6 read 1 with fifos enabled, else 0; reset 0
// - bits 5 and 4 active only with enhanced feature bit 4 set; reset 0
// - xoff indication in bit 4 holds 1 until xon characters arrive
// - bit 0 reads 0 while any interrupt pends, 1 when none; reset 1
// - in fifo mode, data interrupt raised when rx count equals trigger 1,4,8,14
`ifndef UIP_MAP_VH
`define UIP_MAP_VH

// byte addresses of the registers
`define UIP_ADDR_IDENT 4'h0
`define UIP_ADDR_FIFO_CTRL 4'h4
`define UIP_ADDR_ENH_CTRL 4'h8
`define UIP_ADDR_ENABLE 4'hc

// fifo control fields
`define UIP_FCR_EN 0
`define UIP_FCR_TRIG_HI 7
`define UIP_FCR_TRIG_LO 6
// enhanced feature enable bit
`define UIP_EFR_ENH 4

// reset values
`define UIP_RST_IDENT 8'h01
`define UIP_RST_FCR 8'h00
`define UIP_RST_EFR 8'h00
`define UIP_RST_IER 8'h00

// source indices in the pending vector
`define UIP_SRC_LSR 0
`define UIP_SRC_RXD 1
`define UIP_SRC_RTO 2
`define UIP_SRC_THR 3
`define UIP_SRC_MSR 4
`define UIP_SRC_XOF 5
`define UIP_SRC_FLW 6
`define UIP_NSRC 7

// identification codes for bits 5..0
`define UIP_CODE_LSR 6'h06
`define UIP_CODE_RXD 6'h04
`define UIP_CODE_RTO 6'h0c
`define UIP_CODE_THR 6'h02
`define UIP_CODE_MSR 6'h00
`define UIP_CODE_XOF 6'h10
`define UIP_CODE_FLW 6'h20
`define UIP_CODE_NONE 6'h01

// rx trigger levels in bytes
`define UIP_TRIG_0 5'h01
`define UIP_TRIG_1 5'h04
`define UIP_TRIG_2 5'h08
`define UIP_TRIG_3 5'h0e

`endif

// file: hdl/uip_rank.v
// priority encoder: picks the most urgent pending source and its code
// assumes the pending vector is registered on the same clock
`timescale 1ns/1ps
`include "uip_map.vh"

module uip_rank
(
  input wire [6:0] pend,
  output reg any,
  output reg [2:0] sel,
  output reg [5:0] code
);

  // lower index wins; time-out and data share level 2, time-out listed later
  always @*
  begin
    any = 1'b1;
    sel = 3'h0;
    code = `UIP_CODE_NONE;
    if (pend[`UIP_SRC_LSR])
    begin
      sel = `UIP_SRC_LSR;
      code = `UIP_CODE_LSR;
    end
    else if (pend[`UIP_SRC_RXD])
    begin
      sel = `UIP_SRC_RXD;
      code = `UIP_CODE_RXD;
    end
    else if (pend[`UIP_SRC_RTO])
    begin
      sel = `UIP_SRC_RTO;
      code = `UIP_CODE_RTO;
    end
    else if (pend[`UIP_SRC_THR])
    begin
      sel = `UIP_SRC_THR;
      code = `UIP_CODE_THR;
    end
    else if (pend[`UIP_SRC_MSR])
    begin
      sel = `UIP_SRC_MSR;
      code = `UIP_CODE_MSR;
    end
    else if (pend[`UIP_SRC_XOF])
    begin
      sel = `UIP_SRC_XOF;
      code = `UIP_CODE_XOF;
    end
    else if (pend[`UIP_SRC_FLW])
    begin
      sel = `UIP_SRC_FLW;
      code = `UIP_CODE_FLW;
    end
    else
      any = 1'b0;
  end

endmodule

// file: hdl/uip_trig.v
// rx fifo trigger compare for the received data source
// assumes the rx count comes from logic on the same clock
`timescale 1ns/1ps
`include "uip_map.vh"

module uip_trig
(
  input wire [1:0] trig_sel,
  input wire [4:0] rx_count,
  output wire hit
);

  function [4:0] trig_level;
    input [1:0] s;
    begin
      case (s)
        2'h0: trig_level = `UIP_TRIG_0;
        2'h1: trig_level = `UIP_TRIG_1;
        2'h2: trig_level = `UIP_TRIG_2;
        default: trig_level = `UIP_TRIG_3;
      endcase
    end
  endfunction

  assign hit = (rx_count == trig_level(trig_sel));

endmodule

// file: verification/uip_chk.sv
// checker for uip_top: register bus handshake and identification read values
// assumes one clock CLK and synchronous active-high RST
`timescale 1ns/1ps
module uip_chk
(
  input wire CLK,
  input wire RST,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  input wire [1:0] AVS_RESPONSE,
  input wire IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire ans = !AVS_WAITREQUEST;
  wire id_rd = ans && AVS_READ && AVS_ADDRESS == 4'h0;
  chk_ans_once: assert property (ans |=> AVS_WAITREQUEST) else $error("waitrequest low twice");
  chk_ans_time: assert property ($rose(AVS_READ || AVS_WRITE) |-> ##2 ans) else $error("late answer");
  chk_idle_wait: assert property (!AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST) else $error("answer unasked");
  chk_bad_addr: assert property (ans && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_RESPONSE == 2'h2) else $error("no error");
  chk_fifo_bits: assert property (id_rd |-> AVS_READDATA[7] == AVS_READDATA[6]) else $error("fifo bits differ");
  chk_tout_code: assert property (id_rd && AVS_READDATA[3] |-> AVS_READDATA[2:0] == 3'h4) else $error("bad code");
  chk_idle_bit0: assert property (id_rd && !$past(IRQ) |-> AVS_READDATA[0]) else $error("bit0 low, idle");
  // irq may only drop through a register access or a reset
  chk_irq_fall: assert property ($fell(IRQ) |-> ans || $past(ans) || $past(ans, 2) || $past(RST))
    else $error("irq dropped alone");
  cover property (id_rd && !AVS_READDATA[0]);
  cover property (ans && AVS_RESPONSE == 2'h2);
  cover property ($rose(IRQ));
endmodule
bind uip_top uip_chk u_chk (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE), .IRQ(IRQ));

// file: verification/uip_host.sv
// host model: avalon-mm master making one access at a time
// assumes the caller treats a cleared ok as a hang
`timescale 1ns/1ps
module uip_host
(
  input wire clk,
  input wire wait_req,
  input wire [31:0] rdata,
  input wire [1:0] resp,
  output logic rd = 1'b0,
  output logic wr = 1'b0,
  output logic [3:0] addr = 4'h0,
  output logic [31:0] wdata = 32'h0
);
  task automatic xfer(input bit w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q, output logic [1:0] r, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(posedge clk);
      ok = !wait_req;
    end
    q = rdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    // stale write data is inverted so nothing can lean on it
    wdata <= ~wdata;
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for uip_top with a host model on the register bus
// assumes event inputs are one-cycle pulses on the same clock
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] ev = 9'h0;
  logic [4:0] rx_count = 5'h0;
  logic [31:0] q;
  logic [1:0] r;
  logic [6:0] v;
  bit ok;
  int bad_count = 0;
  int n_checks = 0;
  int lv [4] = '{1, 4, 8, 14};
  wire rd, wr, wq, irq;
  wire [3:0] ad;
  wire [31:0] wd, rdat;
  wire [1:0] resp;
  initial forever #20 clk = ~clk;
  uip_top u_dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .AVS_RESPONSE(resp),
    .LINE_STATUS_SOURCE(ev[0]), .RX_DATA_READY(ev[1]), .RX_TIMEOUT(ev[2]), .RX_COUNT(rx_count),
    .TX_HOLDING_EMPTY(ev[3]), .MODEM_STATUS_SOURCE(ev[4]), .XOFF_DETECTED(ev[5]), .XON_DETECTED(ev[6]),
    .SPECIAL_CHAR(ev[7]), .FLOW_CHANGE(ev[8]), .IRQ(irq));
  uip_host u_host (.clk(clk), .wait_req(wq), .rdata(rdat), .resp(resp), .rd(rd), .wr(wr), .addr(ad), .wdata(wd));
  task automatic close_out();
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input bit w, input logic [3:0] a, input logic [7:0] d);
    u_host.xfer(w, a, d, q, r, ok);
    if (!ok)
    begin
      bad_count++;
      close_out();
    end
  endtask
  function automatic logic [7:0] id_of(input int s, input bit f);
    logic [5:0] c [8] = '{6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
    return {f, f, c[s]};
  endfunction
  task automatic rd_id(input logic [7:0] e);
    acc(1'b0, 4'h0, 8'h0);
    chk(q, {24'h0, e});
  endtask
  // reads every pending source in rank order, then the idle code
  task automatic drain(input logic [6:0] p, input bit f);
    for (int s = 0; s < 8; s++)
      if (s == 7 || p[s])
        rd_id(id_of(s, f));
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic pulse(input logic [8:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 9'h0;
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(33441));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_id(8'h01);
    acc(1'b0, 4'h4, 8'h0);
    chk(q, 32'h0);
    acc(1'b0, 4'h6, 8'h0);
    chk({30'h0, r}, 32'h2);
    acc(1'b1, 4'hc, 8'h7f);
    pulse(9'h01b);
    chk({31'h0, irq}, 32'h1);
    drain(7'h1b, 1'b0);
    // the transmit report is frozen, so the later line status waits behind it
    pulse(9'h018);
    pulse(9'h001);
    rd_id(8'h02);
    rd_id(8'h06);
    drain(7'h10, 1'b0);
    for (int t = 0; t < 4; t++)
    begin
      acc(1'b1, 4'h4, {t[1:0], 6'h01});
      rx_count <= 5'h0;
      repeat (lv[t]) @(posedge clk) rx_count <= rx_count + 5'h1;
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      drain(7'h02, 1'b1);
    end
    pulse(9'h002);
    rd_id(8'hc1);
    pulse(9'h004);
    drain(7'h04, 1'b1);
    acc(1'b1, 4'h8, 8'h10);
    // a special character ranks at level 5, ahead of the flow change
    pulse(9'h180);
    drain(7'h60, 1'b1);
    pulse(9'h020);
    rd_id(8'hd0);
    rd_id(8'hd1);
    pulse(9'h040);
    rd_id(8'hc1);
    acc(1'b1, 4'h8, 8'h00);
    pulse(9'h1a0);
    rd_id(8'hc1);
    for (int i = 0; i < 20; i++)
    begin
      v = 7'($urandom) & 7'h19;
      pulse({2'h0, v});
      chk({31'h0, irq}, {31'h0, |v});
      drain(v, 1'b1);
    end
    acc(1'b1, 4'hc, 8'h00);
    pulse(9'h001);
    chk({31'h0, irq}, 32'h0);
    rd_id(8'hc1);
    close_out();
  end
endmodule
